//--- verilog/ldc_cfg.svh
// opcode, field and timing constants of the link device command handler
`ifndef LDC_CFG_SVH
`define LDC_CFG_SVH

`define LDC_OP_LINK_CLEAR 8'h00
`define LDC_OP_PASS_THROUGH 8'h01
`define LDC_OP_LOOP_BACK 8'h02
`define LDC_OP_IDENTIFY 8'h03
`define LDC_OP_REPORT_LAST 8'h33
`define LDC_OP_REPORT_FIRST 8'h30
`define LDC_OP_REPEAT_OFF 8'h3d
`define LDC_OP_REPEAT_SLOW 8'h3e
`define LDC_OP_REPEAT_FAST 8'h3f
`define LDC_OP_REG_ACCESS_ERR 8'hfa
`define LDC_OP_SYS_HARD_RESET 8'hfb
`define LDC_OP_TRANSMIT_ERR 8'hfc
`define LDC_OP_CONFIG_ADDR_ERR 8'hfd
`define LDC_OP_DEV_HARD_RESET 8'hfe
`define LDC_OP_PROHIBITED 8'hff

// upper opcode bits of the ranged groups
`define LDC_GRP_AUTO_CONFIG 5'h01
`define LDC_GRP_POLL 4'h1
`define LDC_GRP_REPOLL 4'h2
`define LDC_GRP_PROMPT 5'h08
`define LDC_GRP_ACK 5'h09

`define LDC_ADDR_UNIVERSAL 3'h0
`define LDC_ADDR_RESET 3'h0
`define LDC_SUB_GENERAL 3'h7

`define LDC_CLK_PERIOD_NS 8
`define LDC_RESP_TIME_US 500

`endif

//--- verilog/ldc_pkg.sv
// types shared by the link device command handler
package ldc_pkg;

    typedef struct packed {
        logic is_cmd;
        logic [2:0] addr;
        logic [7:0] body;
    } ldc_frame_type;

    typedef struct packed {
        logic parity_err;
        logic framing_err;
        ldc_frame_type frame;
    } ldc_rx_type;

    typedef enum logic [3:0] {
        LDC_CL_CLEAR,
        LDC_CL_PASS,
        LDC_CL_LOOP,
        LDC_CL_AUTO_CONFIG,
        LDC_CL_USER,
        LDC_CL_REPEAT_OFF,
        LDC_CL_REPEAT_SLOW,
        LDC_CL_REPEAT_FAST,
        LDC_CL_PROMPT,
        LDC_CL_ACK,
        LDC_CL_ERR_NOTICE,
        LDC_CL_DEV_RESET,
        LDC_CL_PROHIBITED,
        LDC_CL_UNSUPPORTED
    } ldc_class_type;

    typedef enum logic [1:0] {
        LDC_REPEAT_NONE,
        LDC_REPEAT_30,
        LDC_REPEAT_60
    } ldc_repeat_type;

    typedef enum logic {
        LDC_MODE_LOOP_BACK,
        LDC_MODE_PASS_THROUGH
    } ldc_mode_type;

    typedef enum {
        LDC_ST_IDLE,
        LDC_ST_SEND,
        LDC_ST_WAIT_USER
    } ldc_state_type;

endpackage

//--- verilog/ldc_opcode_decode.sv
// sorts a command opcode into the class the handler acts on
`timescale 1ns/10ps
`include "ldc_cfg.svh"

module ldc_opcode_decode
    import ldc_pkg::*;
(
    input wire logic [7:0] opcode,
    output ldc_class_type op_class
);

    function automatic ldc_class_type classify(input logic [7:0] op);
        ldc_class_type c;
        c = LDC_CL_UNSUPPORTED;
        if (op == `LDC_OP_LINK_CLEAR) begin
            c = LDC_CL_CLEAR;
        end else if (op == `LDC_OP_PASS_THROUGH) begin
            c = LDC_CL_PASS;
        end else if (op == `LDC_OP_LOOP_BACK) begin
            c = LDC_CL_LOOP;
        end else if (op[7:3] == `LDC_GRP_AUTO_CONFIG) begin
            c = LDC_CL_AUTO_CONFIG;
        end else if (op >= `LDC_OP_IDENTIFY) begin
            if (op < {`LDC_GRP_AUTO_CONFIG, 3'h0}) begin
                c = LDC_CL_USER;
            end
        end
        if (op[7:4] == `LDC_GRP_POLL || op[7:4] == `LDC_GRP_REPOLL) begin
            c = LDC_CL_USER;
        end
        if (op >= `LDC_OP_REPORT_FIRST && op <= `LDC_OP_REPORT_LAST) begin
            c = LDC_CL_USER;
        end
        case (op)
            `LDC_OP_REPEAT_OFF: c = LDC_CL_REPEAT_OFF;
            `LDC_OP_REPEAT_SLOW: c = LDC_CL_REPEAT_SLOW;
            `LDC_OP_REPEAT_FAST: c = LDC_CL_REPEAT_FAST;
            `LDC_OP_TRANSMIT_ERR: c = LDC_CL_ERR_NOTICE;
            `LDC_OP_CONFIG_ADDR_ERR: c = LDC_CL_ERR_NOTICE;
            `LDC_OP_DEV_HARD_RESET: c = LDC_CL_DEV_RESET;
            `LDC_OP_PROHIBITED: c = LDC_CL_PROHIBITED;
            default: begin
            end
        endcase
        if (op[7:3] == `LDC_GRP_PROMPT) begin
            c = LDC_CL_PROMPT;
        end
        if (op[7:3] == `LDC_GRP_ACK) begin
            c = LDC_CL_ACK;
        end
        return c;
    endfunction

    always_comb begin
        op_class = classify(opcode);
    end

endmodule

//--- verilog/ldc_address_filter.sv
// decides whether a frame is for this device
`timescale 1ns/10ps
`include "ldc_cfg.svh"

module ldc_address_filter (
    input wire logic [2:0] frame_address_field,
    input wire logic [2:0] match_addr,
    output logic accept
);

    always_comb begin
        accept = (frame_address_field == `LDC_ADDR_UNIVERSAL) ||
                 (frame_address_field == match_addr);
    end

endmodule

//--- verilog/ldc_command_handler.sv
// command handling core of a daisy-chained link input device
//
// Function
// - 00h clear, 01h pass-through, 02h loop-back
// - FCh/FDh decode as error notices, FEh as device reset; FAh/FBh as unsupported
// - 40h..47h prompts, 48h..4Fh acknowledges
// - 3Dh repeat off, 3Eh/3Fh repeat on
// - 30h..33h report commands, 34h..3Ch reserved
// - 08h..0Fh auto-configure, 03h..07h consecutive before
// - command returns after addressed device data frames
// - response frame begins within 500 microseconds; a longer user wait only raises response_late
// - address zero universal, one to seven specific
// - commands other than auto-configure and FFh return unchanged, address bits included
// - accept universal or match address frames
// - foreign frames retransmitted, not acted on
// - parity or framing errors always handled
// - unsupported commands retransmitted unchanged
// - host data frames consumed, never retransmitted
// - FFh sets power-up, error frame if new
// - link clear drops power-up, then retransmits
// - loop-back command switches mode, then retransmits
// - auto-configure takes, increments, retransmits address
`timescale 1ns/10ps
`include "ldc_cfg.svh"

module ldc_command_handler
    import ldc_pkg::*;
#(
    parameter int RESP_CYCLES =
        `LDC_RESP_TIME_US * 1000 / `LDC_CLK_PERIOD_NS
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic rx_valid,
    input ldc_rx_type rx,
    output logic rx_ready,
    output logic tx_valid,
    output ldc_frame_type tx_frame,
    input wire logic tx_ready,
    output logic user_cmd_valid,
    output logic [7:0] user_cmd_opcode,
    output logic user_rx_valid,
    output logic [7:0] user_rx_data,
    input wire logic user_data_valid,
    input wire logic [7:0] user_data,
    output logic user_data_ready,
    input wire logic user_done,
    output logic prompt_valid,
    output logic ack_valid,
    output logic [2:0] prompt_index,
    output logic [2:0] match_addr,
    output logic power_up,
    output ldc_mode_type link_mode,
    output ldc_repeat_type repeat_mode,
    output logic response_late
);

    ldc_state_type state;
    ldc_state_type next_state;
    ldc_class_type op_class;
    ldc_frame_type held_cmd;
    ldc_frame_type next_frame;
    logic next_send;
    logic accept;
    logic take;
    logic rx_err;
    logic [2:0] op_low;
    logic [2:0] op_low_next;
    logic [31:0] resp_timer;

    ////////////////////////////////////////////////////////////////////////
    ldc_opcode_decode u_decode (
        .opcode(rx.frame.body),
        .op_class(op_class)
    );

    ldc_address_filter u_filter (
        .frame_address_field(rx.frame.addr),
        .match_addr(match_addr),
        .accept(accept)
    );

    assign take = rx_valid && rx_ready;
    assign rx_err = rx.parity_err || rx.framing_err;
    assign op_low = rx.frame.body[2:0];
    assign op_low_next = op_low + 3'h1;

    ////////////////////////////////////////////////////////////////////////
    // next state and the frame to be sent on the link
    always_comb begin
        next_state = state;
        next_send = 1'b0;
        next_frame = rx.frame;
        case (state)
            LDC_ST_IDLE: begin
                if (take) begin
                    if (rx_err) begin
                        next_frame = '{1'b1, match_addr,
                                       `LDC_OP_TRANSMIT_ERR};
                        next_send = !power_up;
                    end else if (!accept) begin
                        next_send = 1'b1;
                    end else if (rx.frame.is_cmd) begin
                        case (op_class)
                            LDC_CL_USER: begin
                                next_state = LDC_ST_WAIT_USER;
                            end
                            LDC_CL_PROHIBITED: begin
                                next_frame = '{1'b1, match_addr,
                                               `LDC_OP_TRANSMIT_ERR};
                                next_send = !power_up;
                            end
                            LDC_CL_AUTO_CONFIG: begin
                                next_send = 1'b1;
                                if (op_low == `LDC_ADDR_RESET) begin
                                    next_frame.body =
                                        `LDC_OP_CONFIG_ADDR_ERR;
                                end else begin
                                    next_frame.body[2:0] = op_low_next;
                                end
                            end
                            default: begin
                                next_send = 1'b1;
                            end
                        endcase
                    end
                end
                if (next_send) begin
                    next_state = LDC_ST_SEND;
                end
            end
            LDC_ST_SEND: begin
                if (tx_valid && tx_ready) begin
                    next_state = LDC_ST_IDLE;
                end
            end
            LDC_ST_WAIT_USER: begin
                if (!tx_valid && user_data_valid) begin
                    next_send = 1'b1;
                    next_frame = '{1'b0, match_addr, user_data};
                end else if (!tx_valid && user_done) begin
                    // data first, then the command itself
                    next_send = 1'b1;
                    next_frame = held_cmd;
                    next_state = LDC_ST_SEND;
                end
            end
            default: begin
                next_state = LDC_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= LDC_ST_IDLE;
            rx_ready <= 1'b0;
        end else begin
            state <= next_state;
            rx_ready <= (next_state == LDC_ST_IDLE);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // link transmit register
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            tx_valid <= 1'b0;
            tx_frame <= '0;
        end else if (next_send) begin
            tx_valid <= 1'b1;
            tx_frame <= next_frame;
        end else if (tx_valid && tx_ready) begin
            tx_valid <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            held_cmd <= '0;
        end else if (take) begin
            held_cmd <= rx.frame;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // device state kept across commands
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            match_addr <= `LDC_ADDR_RESET;
            power_up <= 1'b1;
            link_mode <= LDC_MODE_LOOP_BACK;
            repeat_mode <= LDC_REPEAT_NONE;
        end else if (take && rx_err) begin
            power_up <= 1'b1;
        end else if (take && accept && rx.frame.is_cmd) begin
            case (op_class)
                LDC_CL_CLEAR: power_up <= 1'b0;
                LDC_CL_PASS: link_mode <= LDC_MODE_PASS_THROUGH;
                LDC_CL_LOOP: link_mode <= LDC_MODE_LOOP_BACK;
                LDC_CL_REPEAT_OFF: repeat_mode <= LDC_REPEAT_NONE;
                LDC_CL_REPEAT_SLOW: repeat_mode <= LDC_REPEAT_30;
                LDC_CL_REPEAT_FAST: repeat_mode <= LDC_REPEAT_60;
                LDC_CL_ERR_NOTICE: power_up <= 1'b1;
                LDC_CL_PROHIBITED: power_up <= 1'b1;
                LDC_CL_AUTO_CONFIG: begin
                    if (op_low == `LDC_ADDR_RESET) begin
                        power_up <= 1'b1;
                    end else begin
                        match_addr <= op_low;
                    end
                end
                LDC_CL_DEV_RESET: begin
                    match_addr <= `LDC_ADDR_RESET;
                    power_up <= 1'b1;
                    link_mode <= LDC_MODE_LOOP_BACK;
                    repeat_mode <= LDC_REPEAT_NONE;
                end
                default: begin
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // user side notices
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            user_cmd_valid <= 1'b0;
            user_cmd_opcode <= 8'h00;
            user_rx_valid <= 1'b0;
            user_rx_data <= 8'h00;
        end else begin
            user_cmd_valid <= take && !rx_err && accept &&
                              rx.frame.is_cmd && op_class == LDC_CL_USER;
            // host data is handed inward only
            user_rx_valid <= take && !rx_err && accept && !rx.frame.is_cmd;
            if (take) begin
                user_cmd_opcode <= rx.frame.body;
                user_rx_data <= rx.frame.body;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            user_data_ready <= 1'b0;
        end else begin
            user_data_ready <= (next_state == LDC_ST_WAIT_USER) &&
                               !next_send && !(tx_valid && !tx_ready);
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            prompt_valid <= 1'b0;
            ack_valid <= 1'b0;
            prompt_index <= 3'h0;
        end else begin
            prompt_valid <= take && !rx_err && accept &&
                            rx.frame.is_cmd && op_class == LDC_CL_PROMPT;
            ack_valid <= take && !rx_err && accept &&
                         rx.frame.is_cmd && op_class == LDC_CL_ACK;
            if (take) begin
                // index zero marks the general prompt or acknowledge
                prompt_index <= (op_low == `LDC_SUB_GENERAL) ?
                                3'h0 : op_low_next;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // watch on the time to the next response frame
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            resp_timer <= 32'h0;
            response_late <= 1'b0;
        end else begin
            if (state == LDC_ST_WAIT_USER && !tx_valid && !next_send) begin
                resp_timer <= resp_timer + 32'h1;
            end else begin
                resp_timer <= 32'h0;
            end
            response_late <= (resp_timer == 32'(RESP_CYCLES - 1)) &&
                             state == LDC_ST_WAIT_USER && !next_send;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    chk_foreign_retransmit: assert property (
        take && !rx_err && !accept |=> tx_valid &&
        tx_frame == $past(rx.frame))
        else $error("foreign frame not passed on unchanged");

    chk_data_consumed: assert property (
        take && !rx_err && accept && !rx.frame.is_cmd |=>
        !tx_valid && user_rx_valid && state == LDC_ST_IDLE)
        else $error("host data frame was retransmitted");

    chk_clear_power_up: assert property (
        take && !rx_err && accept && rx.frame.is_cmd &&
        op_class == LDC_CL_CLEAR |=> !power_up && tx_valid &&
        tx_frame == $past(rx.frame))
        else $error("link clear mishandled");

    chk_prohibited_opcode: assert property (
        take && !rx_err && accept && rx.frame.is_cmd &&
        op_class == LDC_CL_PROHIBITED |=> power_up &&
        (tx_valid == !$past(power_up)))
        else $error("prohibited opcode mishandled");

    chk_auto_config_addr: assert property (
        take && !rx_err && accept && rx.frame.is_cmd &&
        op_class == LDC_CL_AUTO_CONFIG && op_low != 3'h0 |=>
        match_addr == $past(op_low) &&
        tx_frame.body[2:0] == $past(op_low_next))
        else $error("auto-configure address wrong");

    chk_loop_back_mode: assert property (
        take && !rx_err && accept && rx.frame.is_cmd &&
        op_class == LDC_CL_LOOP |=> link_mode == LDC_MODE_LOOP_BACK
        ##0 tx_valid)
        else $error("loop-back not entered");

    chk_error_frame: assert property (
        take && rx_err && !power_up |=> power_up && tx_valid &&
        tx_frame.body == `LDC_OP_TRANSMIT_ERR)
        else $error("error frame not sent");

    chk_unsupported_pass: assert property (
        take && !rx_err && accept && rx.frame.is_cmd &&
        op_class == LDC_CL_UNSUPPORTED |=> $stable(match_addr) &&
        tx_frame == $past(rx.frame))
        else $error("unsupported command altered");

    chk_cmd_after_data: assert property (
        state == LDC_ST_WAIT_USER && !tx_valid && !user_data_valid &&
        user_done |=> tx_valid && tx_frame == $past(held_cmd))
        else $error("command not returned after data");

    chk_retransmit_prompt: assert property (
        take && !rx_err && op_class != LDC_CL_USER &&
        op_class != LDC_CL_PROHIBITED && !(accept && !rx.frame.is_cmd)
        |-> ##[1:2] tx_valid)
        else $error("response frame late");

endmodule

//--- dv/ldc_link_host.sv
// host and downstream link model facing the command handler
`timescale 1ns/10ps

module ldc_link_host
    import ldc_pkg::*;
(
    input wire logic sys_clk,
    output logic rx_valid,
    output ldc_rx_type rx,
    input wire logic rx_ready,
    input wire logic tx_valid,
    input ldc_frame_type tx_frame,
    output logic tx_ready
);

    initial begin
        rx_valid = 1'h0;
        rx = '0;
        tx_ready = 1'h0;
    end

    ////////////////////////////////////////////////////////////////////////
    // one frame on the line at a time, held until taken or 40 cycles have passed
    // opcode ffh is sent only when a scenario asks for it
    task automatic send_frame(input ldc_rx_type f);
        logic was_ready;
        int n;
        n = 0;
        rx = f;
        rx_valid = 1'h1;
        do begin
            was_ready = rx_ready;
            @(posedge sys_clk);
            #1;
            n++;
        end while (!was_ready && n < 40);
        rx_valid = 1'h0;
        // released line shows the inverse of the last frame
        rx = ldc_rx_type'(~f);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // bounded wait stands for the host response timeout
    task automatic get_frame(input int stall, output ldc_frame_type f,
                             output bit got);
        int n;
        n = 0;
        got = 1'h0;
        f = '0;
        while (!tx_valid && n < 40) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        if (tx_valid) begin
            repeat (stall) begin
                @(posedge sys_clk);
                #1;
            end
            f = tx_frame;
            got = 1'h1;
            tx_ready = 1'h1;
            @(posedge sys_clk);
            #1;
            tx_ready = 1'h0;
        end
    endtask

endmodule

//--- dv/test_link_device_command_handler.sv
// self-checking bench of the link device command handler
`timescale 1ns/10ps

module test_link_device_command_handler
    import ldc_pkg::*;
;
    logic sys_clk = 1'h0;
    logic reset_n, rx_valid, rx_ready, tx_valid, tx_ready;
    ldc_rx_type rx;
    ldc_frame_type tx_frame;
    logic user_cmd_valid, user_rx_valid, user_data_valid, user_data_ready;
    logic user_done, prompt_valid, ack_valid, power_up, response_late;
    logic [7:0] user_cmd_opcode, user_rx_data, user_data, last_op, last_rx;
    logic [2:0] prompt_index, match_addr, last_index;
    ldc_mode_type link_mode;
    ldc_repeat_type repeat_mode;
    int num_errors = 0;
    int n_tests = 0;
    int n_prompt = 0, n_ack = 0, n_ucmd = 0, n_urx = 0, n_late = 0;

    always #4 sys_clk = ~sys_clk;

    ldc_command_handler #(.RESP_CYCLES(20)) u_dut (.sys_clk(sys_clk),
        .reset_n(reset_n), .rx_valid(rx_valid), .rx(rx),
        .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_frame(tx_frame),
        .tx_ready(tx_ready), .user_cmd_valid(user_cmd_valid),
        .user_cmd_opcode(user_cmd_opcode), .user_rx_valid(user_rx_valid),
        .user_rx_data(user_rx_data), .user_data_valid(user_data_valid),
        .user_data(user_data), .user_data_ready(user_data_ready),
        .user_done(user_done), .prompt_valid(prompt_valid),
        .ack_valid(ack_valid), .prompt_index(prompt_index),
        .match_addr(match_addr), .power_up(power_up),
        .link_mode(link_mode), .repeat_mode(repeat_mode),
        .response_late(response_late));

    ldc_link_host u_host (.sys_clk(sys_clk), .rx_valid(rx_valid), .rx(rx),
        .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_frame(tx_frame),
        .tx_ready(tx_ready));

    // pulse outputs are counted so tasks can compare before and after
    always @(posedge sys_clk) begin
        if (prompt_valid) begin
            n_prompt++;
            last_index = prompt_index;
        end
        if (ack_valid) begin
            n_ack++;
            last_index = prompt_index;
        end
        if (user_cmd_valid) begin
            n_ucmd++;
            last_op = user_cmd_opcode;
        end
        if (user_rx_valid) begin
            n_urx++;
            last_rx = user_rx_data;
        end
        if (response_late) n_late++;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string name, input logic [15:0] seen,
                         input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d errors %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic xfer(input logic [1:0] err, input logic is_cmd,
                        input logic [2:0] a, input logic [7:0] b,
                        output ldc_frame_type f, output bit got);
        u_host.send_frame({err, is_cmd, a, b});
        u_host.get_frame(int'(b[1:0]), f, got);
    endtask

    task automatic echo(input logic [2:0] a, input logic [7:0] b);
        ldc_frame_type f;
        bit got;
        xfer(2'h0, 1'h1, a, b, f, got);
        check("returned", {got, f}, {1'h1, 1'h1, a, b});
    endtask

    task automatic state(input logic [6:0] exp);
        check("state", {match_addr, power_up, link_mode, repeat_mode}, exp);
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_errors();
        ldc_frame_type f;
        bit got;
        echo(3'h0, 8'h00);
        check("pwr_clr", power_up, 1'h0);
        xfer(2'h2, 1'h1, 3'h6, 8'h31, f, got);
        check("err", {got, f}, {1'h1, 1'h1, 3'h0, 8'hfc});
        check("pwr_set", power_up, 1'h1);
        xfer(2'h1, 1'h1, 3'h6, 8'h31, f, got);
        check("no_err", got, 1'h0);
        echo(3'h0, 8'h00);
        xfer(2'h0, 1'h1, 3'h0, 8'hff, f, got);
        check("ff_err", {got, f}, {1'h1, 1'h1, 3'h0, 8'hfc});
        echo(3'h0, 8'h00);
        echo(3'h0, 8'hfc);
        check("notice_pwr", power_up, 1'h1);
        echo(3'h0, 8'h00);
    endtask

    task automatic t_autocfg();
        ldc_frame_type f;
        bit got;
        xfer(2'h0, 1'h1, 3'h0, 8'h09, f, got);
        check("cfg", {got, f}, {1'h1, 1'h1, 3'h0, 8'h0a});
        check("addr", match_addr, 3'h1);
        xfer(2'h0, 1'h1, 3'h0, 8'h08, f, got);
        check("cfg_err", {got, f.is_cmd, f.body}, {2'h3, 8'hfd});
        check("cfg_err_pwr", power_up, 1'h1);
        echo(3'h0, 8'h00);
        xfer(2'h0, 1'h1, 3'h0, 8'h09, f, got);
        check("readdr", match_addr, 3'h1);
    endtask

    task automatic t_modes();
        logic [7:0] ops [5] = '{8'h3d, 8'h3e, 8'h3f, 8'h01, 8'h02};
        logic [2:0] exp [5] = '{3'h0, 3'h1, 3'h2, 3'h6, 3'h2};
        for (int i = 0; i < 5; i++) begin
            echo(3'h1, ops[i]);
            check("mode", {link_mode, repeat_mode}, exp[i]);
        end
    endtask

    task automatic t_prompts();
        logic [7:0] ops [6] = '{8'h40, 8'h46, 8'h47, 8'h48, 8'h4e, 8'h4f};
        logic [2:0] idx [6] = '{3'h1, 3'h7, 3'h0, 3'h1, 3'h7, 3'h0};
        int p0, a0;
        for (int i = 0; i < 6; i++) begin
            p0 = n_prompt;
            a0 = n_ack;
            echo(3'h1, ops[i]);
            check("prompt", {2'(n_prompt - p0), 2'(n_ack - a0), last_index},
                  {1'h0, !ops[i][3], 1'h0, ops[i][3], idx[i]});
        end
    endtask

    task automatic t_foreign();
        ldc_frame_type f;
        bit got;
        int u0;
        u0 = n_ucmd + n_urx;
        echo(3'h5, 8'h3d);
        check("foreign", repeat_mode, 2'h2);
        xfer(2'h0, 1'h0, 3'h5, 8'h77, f, got);
        check("fdata", {got, f}, {1'h1, 1'h0, 3'h5, 8'h77});
        check("fuser", 8'(n_ucmd + n_urx - u0), 8'h0);
        echo(3'h0, 8'h34);
        echo(3'h0, 8'h3c);
        echo(3'h0, 8'h50);
        echo(3'h0, 8'hfa);
        echo(3'h7, 8'hfb);
    endtask

    task automatic t_data();
        ldc_frame_type f;
        bit got;
        int u0;
        u0 = n_urx;
        xfer(2'h0, 1'h0, 3'h1, 8'h5a, f, got);
        check("consumed", got, 1'h0);
        check("urx", {8'(n_urx - u0), last_rx}, {8'h1, 8'h5a});
    endtask

    task automatic t_user(input logic [7:0] op, input logic [7:0] b,
                          input bit late);
        ldc_frame_type f;
        bit got;
        int u0, l0, n;
        u0 = n_ucmd;
        l0 = n_late;
        n = 0;
        u_host.send_frame({2'h0, 1'h1, 3'h1, op});
        while (n_ucmd == u0 && n < 20) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        check("ucmd", last_op, op);
        if (late) begin
            repeat (25) @(posedge sys_clk);
            #1;
            check("late", n_late > l0, 1'h1);
        end else begin
            check("udata_rdy", user_data_ready, 1'h1);
            user_data = b;
            user_data_valid = 1'h1;
            @(posedge sys_clk);
            #1;
            user_data_valid = 1'h0;
            user_data = ~b;
            check("udata_busy", user_data_ready, 1'h0);
            u_host.get_frame(1, f, got);
            check("udata", {got, f}, {1'h1, 1'h0, 3'h1, b});
            check("not_late", n_late == l0, 1'h1);
        end
        user_done = 1'h1;
        u_host.get_frame(0, f, got);
        user_done = 1'h0;
        check("ucmd_ret", {got, f}, {1'h1, 1'h1, 3'h1, op});
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        reset_n = 1'h0;
        user_data_valid = 1'h0;
        user_data = 8'h00;
        user_done = 1'h0;
        repeat (6) @(posedge sys_clk);
        #1;
        state(7'h08);
        reset_n = 1'h1;
        t_errors();
        t_autocfg();
        t_modes();
        t_prompts();
        t_foreign();
        t_data();
        t_user(8'h10, 8'ha5, 1'h0);
        t_user(8'h03, 8'h00, 1'h1);
        echo(3'h0, 8'hfe);
        state(7'h08);
        end_of_test();
    end

    initial begin
        #100000;
        num_errors++;
        end_of_test();
    end

endmodule
